//--- inc/quad_decoder_pkg.sv
`default_nettype none

package quad_decoder_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int ADDR_W  = 16;
    localparam int DATA_W  = 8;
    localparam int COUNT_W = 8;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] X_DIRECTION_OFFSET      = 16'h2560;
    localparam logic [ADDR_W-1:0] X_MOVEMENT_COUNT_OFFSET = 16'h2561;
    localparam logic [ADDR_W-1:0] Y_DIRECTION_OFFSET      = 16'h2562;
    localparam logic [ADDR_W-1:0] Y_MOVEMENT_COUNT_OFFSET = 16'h2563;
    localparam logic [ADDR_W-1:0] Z_DIRECTION_OFFSET      = 16'h2564;
    localparam logic [ADDR_W-1:0] Z_MOVEMENT_COUNT_OFFSET = 16'h2565;
    localparam logic [ADDR_W-1:0] DECODER_CONTROL_OFFSET  = 16'h2566;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int DIR_BIT         = 0;
    localparam int CTRL_MODE_BIT   = 0;
    localparam int CTRL_INIT_BIT   = 1;
    localparam int CTRL_ENABLE_BIT = 2;

    // ----------------------------------------------------------------
    // values after reset and fixed answers
    // ----------------------------------------------------------------
    localparam logic [COUNT_W-1:0] COUNT_RESET   = 8'h00;
    localparam logic [COUNT_W-1:0] COUNT_ONE     = 8'h01;
    localparam logic               DIR_RESET     = 1'b0;
    localparam logic [DATA_W-1:0]  READ_ZERO     = 8'h00;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic phase_a;
        logic phase_b;
    } quad_pins_t;

    typedef struct packed {
        logic decoder_enable;
        logic decoder_init;
        logic count_up_mode;
    } control_t;

    typedef struct packed {
        logic               dir;
        logic [COUNT_W-1:0] count;
    } axis_state_t;

    localparam control_t    CONTROL_RESET = '{decoder_enable: 1'b0, decoder_init: 1'b0, count_up_mode: 1'b0};
    localparam axis_state_t AXIS_RESET    = '{dir: 1'b0, count: 8'h00};

endpackage

`default_nettype wire

//--- logic/quad_axis.sv
`timescale 1ns/1ps
`default_nettype none

module quad_axis (
    input  wire logic                          clk_sys_in,
    input  wire logic                          rst_in,
    input  wire quad_decoder_pkg::quad_pins_t  pins_in,
    input  wire logic                          enable_in,
    input  wire logic                          init_in,
    input  wire logic                          count_up_mode_in,
    output var  quad_decoder_pkg::axis_state_t state_out
);

    // ----------------------------------------------------------------
    // step detection
    // ----------------------------------------------------------------
    quad_decoder_pkg::quad_pins_t  prev_pins;
    quad_decoder_pkg::axis_state_t state;
    logic                          a_moved;
    logic                          b_moved;
    logic                          step;
    logic                          a_leads;
    logic                          next_dir;

    assign a_moved = pins_in.phase_a ^ prev_pins.phase_a;
    assign b_moved = pins_in.phase_b ^ prev_pins.phase_b;
    // one edge is one quarter step
    assign step    = a_moved ^ b_moved;
    assign a_leads  = a_moved ? (pins_in.phase_a != pins_in.phase_b)
                              : (pins_in.phase_a == pins_in.phase_b);
    assign next_dir = ~a_leads;     // 1 = up, 0 = down

    // previous pin levels, tracked even while disabled
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            prev_pins <= '0;
        end else begin
            prev_pins <= pins_in;
        end
    end

    // ----------------------------------------------------------------
    // direction and count
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state <= quad_decoder_pkg::AXIS_RESET;
        end else if (init_in) begin
            state <= quad_decoder_pkg::AXIS_RESET;
        end else if (enable_in && step) begin
            if (next_dir != state.dir) begin
                state.dir   <= next_dir;
                state.count <= quad_decoder_pkg::COUNT_RESET;
            end else if (count_up_mode_in) begin
                state.count <= state.count + quad_decoder_pkg::COUNT_ONE;
            end else begin
                state.count <= state.count - quad_decoder_pkg::COUNT_ONE;
            end
        end
    end

    assign state_out = state;

endmodule

`default_nettype wire

//--- logic/quadrature_pointer_decoder.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module quadrature_pointer_decoder (
    input  wire logic                                  clk_sys_in,
    input  wire logic                                  rst_in,
    input  wire logic [quad_decoder_pkg::ADDR_W-1:0]   addr_in,
    input  wire logic [quad_decoder_pkg::DATA_W-1:0]   wr_data_in,
    input  wire logic                                  wr_en_in,
    input  wire logic                                  rd_en_in,
    output var  logic [quad_decoder_pkg::DATA_W-1:0]   rd_data_out,
    input  wire logic                                  x_phase_a_in,
    input  wire logic                                  x_phase_b_in,
    input  wire logic                                  y_phase_a_in,
    input  wire logic                                  y_phase_b_in,
    input  wire logic                                  z_phase_a_in,
    input  wire logic                                  z_phase_b_in
);

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    quad_decoder_pkg::control_t    control;
    quad_decoder_pkg::quad_pins_t  x_pins;
    quad_decoder_pkg::quad_pins_t  y_pins;
    quad_decoder_pkg::quad_pins_t  z_pins;
    quad_decoder_pkg::axis_state_t x_state;
    quad_decoder_pkg::axis_state_t y_state;
    quad_decoder_pkg::axis_state_t z_state;
    logic                          control_write;
    logic [quad_decoder_pkg::DATA_W-1:0] next_rd_data;

    assign control_write = wr_en_in && (addr_in == quad_decoder_pkg::DECODER_CONTROL_OFFSET);

    // enable and mode hold; init is a one-cycle pulse
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            control <= quad_decoder_pkg::CONTROL_RESET;
        end else if (control_write) begin
            control.decoder_enable <= wr_data_in[quad_decoder_pkg::CTRL_ENABLE_BIT];
            control.decoder_init   <= wr_data_in[quad_decoder_pkg::CTRL_INIT_BIT];
            control.count_up_mode  <= wr_data_in[quad_decoder_pkg::CTRL_MODE_BIT];
        end else begin
            control.decoder_init   <= 1'b0;  // self-clearing
        end
    end

    // ----------------------------------------------------------------
    // axis decoders
    // ----------------------------------------------------------------
    assign x_pins = '{phase_a: x_phase_a_in, phase_b: x_phase_b_in};
    assign y_pins = '{phase_a: y_phase_a_in, phase_b: y_phase_b_in};
    assign z_pins = '{phase_a: z_phase_a_in, phase_b: z_phase_b_in};

    quad_axis x_axis (
        .clk_sys_in       (clk_sys_in),
        .rst_in           (rst_in),
        .pins_in          (x_pins),
        .enable_in        (control.decoder_enable),
        .init_in          (control.decoder_init),
        .count_up_mode_in (control.count_up_mode),
        .state_out        (x_state)
    );

    quad_axis y_axis (
        .clk_sys_in       (clk_sys_in),
        .rst_in           (rst_in),
        .pins_in          (y_pins),
        .enable_in        (control.decoder_enable),
        .init_in          (control.decoder_init),
        .count_up_mode_in (control.count_up_mode),
        .state_out        (y_state)
    );

    quad_axis z_axis (
        .clk_sys_in       (clk_sys_in),
        .rst_in           (rst_in),
        .pins_in          (z_pins),
        .enable_in        (control.decoder_enable),
        .init_in          (control.decoder_init),
        .count_up_mode_in (control.count_up_mode),
        .state_out        (z_state)
    );

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // read mux; reserved bits and unmapped addresses give zero
    always_comb begin
        next_rd_data = quad_decoder_pkg::READ_ZERO;
        case (addr_in)
            quad_decoder_pkg::X_DIRECTION_OFFSET:
                next_rd_data[quad_decoder_pkg::DIR_BIT] = x_state.dir;
            quad_decoder_pkg::X_MOVEMENT_COUNT_OFFSET:
                next_rd_data = x_state.count;
            quad_decoder_pkg::Y_DIRECTION_OFFSET:
                next_rd_data[quad_decoder_pkg::DIR_BIT] = y_state.dir;
            quad_decoder_pkg::Y_MOVEMENT_COUNT_OFFSET:
                next_rd_data = y_state.count;
            quad_decoder_pkg::Z_DIRECTION_OFFSET:
                next_rd_data[quad_decoder_pkg::DIR_BIT] = z_state.dir;
            quad_decoder_pkg::Z_MOVEMENT_COUNT_OFFSET:
                next_rd_data = z_state.count;
            quad_decoder_pkg::DECODER_CONTROL_OFFSET: begin
                next_rd_data[quad_decoder_pkg::CTRL_ENABLE_BIT] = control.decoder_enable;
                next_rd_data[quad_decoder_pkg::CTRL_INIT_BIT]   = control.decoder_init;
                next_rd_data[quad_decoder_pkg::CTRL_MODE_BIT]   = control.count_up_mode;
            end
            default: next_rd_data = quad_decoder_pkg::READ_ZERO;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_out <= quad_decoder_pkg::READ_ZERO;
        end else if (rd_en_in) begin
            rd_data_out <= next_rd_data;
        end else begin
            rd_data_out <= quad_decoder_pkg::READ_ZERO;
        end
    end

endmodule

`default_nettype wire

//--- tb/quad_decoder_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// register bus checker
// ----------------------------------------------------------------
module quad_decoder_monitor (
    input wire logic                                clk_sys_in,
    input wire logic                                rst_in,
    input wire logic [quad_decoder_pkg::ADDR_W-1:0] addr_in,
    input wire logic [quad_decoder_pkg::DATA_W-1:0] wr_data_in,
    input wire logic                                wr_en_in,
    input wire logic                                rd_en_in,
    input wire logic [quad_decoder_pkg::DATA_W-1:0] rd_data_out,
    input wire logic                                x_phase_a_in,
    input wire logic                                x_phase_b_in,
    input wire logic                                y_phase_a_in,
    input wire logic                                y_phase_b_in,
    input wire logic                                z_phase_a_in,
    input wire logic                                z_phase_b_in
);
    logic       en_seen;
    wire logic  ctl_wr = wr_en_in && addr_in == quad_decoder_pkg::DECODER_CONTROL_OFFSET;
    wire logic  ctl_rd = rd_en_in && addr_in == quad_decoder_pkg::DECODER_CONTROL_OFFSET;
    wire logic [5:0] ph = {x_phase_a_in, x_phase_b_in, y_phase_a_in, y_phase_b_in, z_phase_a_in, z_phase_b_in};
    // notes any enable write since reset
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            en_seen <= 1'b0;
        end else if (ctl_wr && wr_data_in[2]) begin
            en_seen <= 1'b1;
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    property p_idle_zero;
        !rd_en_in |=> rd_data_out == 8'h00;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("read data not zero outside a read");
    property p_dir_resv;
        rd_en_in && addr_in inside {16'h2560, 16'h2562, 16'h2564} |=> rd_data_out[7:1] == 7'h00;
    endproperty
    a_dir_resv: assert property (p_dir_resv) else $error("direction upper bits not zero");
    property p_ctl_resv;
        ctl_rd |=> rd_data_out[7:3] == 5'h00;
    endproperty
    a_ctl_resv: assert property (p_ctl_resv) else $error("control upper bits not zero");
    property p_unmapped;
        rd_en_in && !(addr_in inside {[16'h2560:16'h2566]}) |=> rd_data_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_quiet;
        rd_en_in && !en_seen && !ctl_rd |=> rd_data_out == 8'h00;
    endproperty
    a_quiet: assert property (p_quiet) else $error("state moved while never enabled");
    property p_init_clear;
        ctl_wr && wr_data_in[1] && !wr_data_in[2] ##1 !wr_en_in ##1 rd_en_in && addr_in == 16'h2561
            |=> rd_data_out == 8'h00;
    endproperty
    a_init_clear: assert property (p_init_clear) else $error("count not cleared by init");
    property p_ctl_back;
        ctl_wr ##1 !wr_en_in ##1 ctl_rd |=> rd_data_out == ($past(wr_data_in, 3) & 8'h05);
    endproperty
    a_ctl_back: assert property (p_ctl_back) else $error("control readback wrong");
    property p_hold;
        !wr_en_in ##1 rd_en_in && $stable(ph) ##1 rd_en_in && $stable(addr_in) && $stable(ph)
            |=> rd_data_out == $past(rd_data_out);
    endproperty
    a_hold: assert property (p_hold) else $error("state changed without a step");
endmodule
`default_nettype wire

//--- tb/quad_mouse_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// quadrature pointing device
// ----------------------------------------------------------------
module quad_mouse_model (
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    input  wire logic [2:0] step_in,
    input  wire logic [2:0] up_in,
    output logic      [5:0] pins_out
);
    logic [1:0] pos [3];
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        for (int i = 0; i < 3; i++) begin
            if (rst_in) begin
                pos[i] <= 2'h0;
            end else if (step_in[i]) begin
                pos[i] <= up_in[i] ? pos[i] - 2'h1 : pos[i] + 2'h1;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pins_out[5 - 2 * i] = pos[i][1] ^ pos[i][0];
            pins_out[4 - 2 * i] = pos[i][1];
        end
    end
endmodule
`default_nettype wire

//--- tb/quadrature_pointer_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// bench top
// ----------------------------------------------------------------
module quadrature_pointer_decoder_tb;
    logic        clk_sys_in, rst_in, wr_en, rd_en, rd_pend;
    logic [15:0] addr;
    logic [7:0]  wdata, rdata, rd_data, exp_q[$];
    logic [2:0]  step, up;
    logic [5:0]  pins;
    logic [31:0] seed;
    int          bad_count, num_checks, cyc, n;

    quadrature_pointer_decoder u_quadrature_pointer_decoder (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .addr_in(addr), .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rd_data),
        .x_phase_a_in(pins[5]), .x_phase_b_in(pins[4]), .y_phase_a_in(pins[3]), .y_phase_b_in(pins[2]),
        .z_phase_a_in(pins[1]), .z_phase_b_in(pins[0]));
    quad_mouse_model u_quad_mouse_model (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .step_in(step),
        .up_in(up), .pins_out(pins));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
        wr_en <= w;
        rd_en <= r;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys_in);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, a, 8'h00);
    endtask
    task automatic move(input int ax, input logic u, input int k);
        bus(1'b0, 1'b0, 16'h0000, 8'h00);
        step <= 3'h1 << ax;
        up <= {3{u}};
        repeat (k) @(posedge clk_sys_in);
        step <= 3'h0;
        repeat (2) @(posedge clk_sys_in);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // clock at 40 MHz
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    // compares each read answer with the oldest note
    always @(posedge clk_sys_in) begin
        rd_pend <= rd_en;
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            final_report();
        end
    end
    always @(negedge clk_sys_in) begin
        if (rd_pend) begin
            rdata = exp_q.pop_front();
            num_checks++;
            if (rd_data !== rdata) begin
                bad_count++;
                $display("wrong value at %0t: got %h expected %h", $time, rd_data, rdata);
            end
        end
    end
    // main sequence
    initial begin
        rst_in = 1'b1;
        wr_en  = 1'b0;
        rd_en  = 1'b0;
        addr   = 16'h0000;
        wdata  = 8'h00;
        step   = 3'h0;
        up     = 3'h0;
        seed   = 32'h0000EBD0;  // xorshift start, 60368
        repeat (5) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        bus(1'b0, 1'b0, 16'h0000, 8'h00);
        for (int i = 0; i < 7; i++) begin
            rd(16'(16'h2560 + i), 8'h00);
        end
        bus(1'b1, 1'b0, 16'h2561, 8'hFF);
        rd(16'(16'h2570 + rnd() % 200), 8'h00);
        rd(16'h2561, 8'h00);
        move(0, 1'b0, 3);
        rd(16'h2561, 8'h00);
        bus(1'b1, 1'b0, 16'h2566, 8'h05);
        rd(16'h2566, 8'h05);
        for (int ax = 0; ax < 3; ax++) begin
            n = 2 + rnd() % 39;
            move(ax, 1'b0, n);
            rd(16'(16'h2560 + 2 * ax), 8'h00);
            rd(16'(16'h2561 + 2 * ax), 8'(n));
            move(ax, 1'b1, n);
            rd(16'(16'h2560 + 2 * ax), 8'h01);
            rd(16'(16'h2561 + 2 * ax), 8'(n - 1));
            rd(16'(16'h2561 + 2 * ax), 8'(n - 1));
        end
        move(0, 1'b0, 258);
        rd(16'h2561, 8'h01);
        bus(1'b1, 1'b0, 16'h2566, 8'h03);
        bus(1'b0, 1'b0, 16'h0000, 8'h00);
        for (int i = 1; i < 7; i++) begin
            rd(16'(16'h2560 + i % 6), 8'h00);
        end
        rd(16'h2566, 8'h01);
        bus(1'b1, 1'b0, 16'h2566, 8'h04);
        bus(1'b0, 1'b0, 16'h0000, 8'h00);
        rd(16'h2566, 8'h04);
        move(1, 1'b0, 2);
        rd(16'h2563, 8'hFE);
        bus(1'b0, 1'b0, 16'h0000, 8'h00);
        bus(1'b0, 1'b0, 16'h0000, 8'h00);
        // reset again in mid-run
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        bus(1'b0, 1'b0, 16'h0000, 8'h00);
        rd(16'h2563, 8'h00);
        rd(16'h2566, 8'h00);
        bus(1'b0, 1'b0, 16'h0000, 8'h00);
        bus(1'b0, 1'b0, 16'h0000, 8'h00);
        final_report();
    end
endmodule

bind quadrature_pointer_decoder quad_decoder_monitor u_quad_decoder_monitor (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .x_phase_a_in(x_phase_a_in), .x_phase_b_in(x_phase_b_in),
    .y_phase_a_in(y_phase_a_in), .y_phase_b_in(y_phase_b_in), .z_phase_a_in(z_phase_a_in),
    .z_phase_b_in(z_phase_b_in));
`default_nettype wire
